// >>> shared/bvr_pkg.sv
// constants, field layouts and mode codes for the byte variable file
// ----------------------------------------------------------------------
// Functional notes
// - fourteen general 8-bit byte registers, indexed 0 to 13, are readable and writable.
// - byte arithmetic into a general register wraps modulo 256 and raises no flag.
// - seven 16-bit word views alias byte 2n+1 as upper and byte 2n as lower half.
// - bytes 0 and 1 also appear as sixteen single-bit flags, byte 0 giving flags 0 to 7.
// - a reset clears all fourteen general bytes and so every word and flag view.
// - the auxiliary byte store is reached only by indirect byte reads and writes, never by arithmetic.
// - the auxiliary store spans addresses 80 to 127, larger builds add a window from 192, the smallest has none.
// - a write to the port data register drives each output pin from its written bit.
// - a read of the port data register returns the sampled input pins, not the outputs.
// - assigning the port data register to itself copies the sampled inputs onto the outputs.
// - with a combined two-way port the direction register picks input or output, bits 1, 2 and 4 only.
// - with a combined two-way port the port data register keeps input bits 1 to 4 only.
// - with split ports a separate byte register receives infrared codes, also read as the key code.
// - in the small two-way build the infrared result register is general byte 13 itself.
// ----------------------------------------------------------------------
package bvr_pkg;
	// sizes
	localparam int BVR_GP_COUNT    = 14;
	localparam int BVR_WORD_COUNT  = 7;
	localparam int BVR_FLAG_COUNT  = 16;
	localparam int BVR_AUX_DEPTH   = 96;
	localparam int BVR_AUX_BANK    = 48;
	localparam int BVR_ADDR_W      = 12;
	localparam logic [3:0] BVR_GP_LAST_IDX = 4'hd;

	// register offsets (byte addresses on the bus)
	localparam logic [11:0] OFS_GP_BASE   = 12'h000;
	localparam logic [11:0] OFS_WORD_BASE = 12'h040;
	localparam logic [11:0] OFS_FLAG_BASE = 12'h080;
	localparam logic [11:0] OFS_PORT      = 12'h0c0;
	localparam logic [11:0] OFS_DIR       = 12'h0c4;
	localparam logic [11:0] OFS_PORT_COPY = 12'h0c8;
	localparam logic [11:0] OFS_ALU       = 12'h0cc;
	localparam logic [11:0] OFS_IR        = 12'h0d0;
	localparam logic [11:0] OFS_AUX_PTR   = 12'h0d4;
	localparam logic [11:0] OFS_AUX_DATA  = 12'h0d8;

	// arithmetic command fields
	localparam int ALU_OPND_LSB = 0;
	localparam int ALU_DST_LSB  = 8;
	localparam int ALU_SUB_BIT  = 12;

	// port masks for the combined two-way build
	localparam logic [7:0] DIR_IMPL_MASK    = 8'h16;
	localparam logic [7:0] PORT_BIDIR_IN_MASK = 8'h1e;

	// auxiliary store windows
	localparam logic [7:0] AUX_LO_BASE = 8'h50;
	localparam logic [7:0] AUX_LO_END  = 8'h7f;
	localparam logic [7:0] AUX_HI_BASE = 8'hc0;
	localparam logic [7:0] AUX_HI_END  = 8'hef;

	// reset values
	localparam logic [7:0] GP_RESET       = 8'h00;
	localparam logic [7:0] PORT_OUT_RESET = 8'h00;
	localparam logic [7:0] DIR_RESET      = 8'h00;
	localparam logic [7:0] IR_RESET       = 8'h00;
	localparam logic [7:0] AUX_PTR_RESET  = 8'h00;

	// build options
	typedef enum logic [1:0] {
		PORT_BIDIR = 2'b01,
		PORT_SPLIT = 2'b10
	} bvr_port_mode_t;

	typedef enum logic [2:0] {
		AUX_NONE  = 3'b001,
		AUX_BASIC = 3'b010,
		AUX_LARGE = 3'b100
	} bvr_aux_mode_t;

	// bus answer phases
	typedef enum logic [2:0] {
		PH_IDLE = 3'b001,
		PH_WAIT = 3'b010,
		PH_ACK  = 3'b100
	} bvr_phase_t;
endpackage

// >>> verilog/bvr_aux_ram.sv
// small byte memory behind the auxiliary store, registered read data
`timescale 1ns/1ps
`default_nettype none
module bvr_aux_ram
	import bvr_pkg::*;
(
	// clock
	input  wire logic       ref_clk,
	// write side
	input  wire logic       wr_en,
	input  wire logic [6:0] wr_idx,
	input  wire logic [7:0] wr_data,
	// read side
	input  wire logic [6:0] rd_idx,
	output logic      [7:0] rd_data
);
	logic [7:0] mem [BVR_AUX_DEPTH];

	// ----------------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------------
	// contents survive reset, as the store is scratch space only
	always_ff @(posedge ref_clk)
	begin
		if (wr_en)
			mem[wr_idx] <= wr_data;
	end

	// read port, one cycle latency
	always_ff @(posedge ref_clk)
	begin
		rd_data <= mem[rd_idx];
	end
endmodule
`default_nettype wire

// >>> verilog/bvr_var_file.sv
// byte variable file with word and flag views, aux store and port registers
//
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module bvr_var_file
	import bvr_pkg::*;
#(
	parameter bvr_port_mode_t PORT_MODE = PORT_SPLIT,
	parameter bvr_aux_mode_t  AUX_MODE  = AUX_BASIC
)
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// avalon-mm slave
	input  wire logic [11:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// port pins
	input  wire logic [7:0]  in_pins,
	output logic      [7:0]  out_pins,
	output logic      [7:0]  out_pins_oe,
	// infrared receiver
	input  wire logic        ir_code_valid,
	input  wire logic [7:0]  ir_code
);
	// ----------------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------------
	// true when addr hits an aligned word of a table of count entries
	function automatic logic in_table(input logic [11:0] addr,
		input logic [11:0] base, input int count);
		logic [11:0] top;
		top = base + 12'(count * 4);
		return (addr >= base) && (addr < top) && (addr[1:0] == 2'b00);
	endfunction

	// entry number inside a table
	function automatic logic [3:0] tab_idx(input logic [11:0] addr,
		input logic [11:0] base);
		logic [11:0] diff;
		diff = addr - base;
		return diff[5:2];
	endfunction

	// pointer falls in a window that this build really has
	function automatic logic aux_mapped(input logic [7:0] ptr);
		logic lo;
		logic hi;
		lo = (ptr >= AUX_LO_BASE) && (ptr <= AUX_LO_END);
		hi = (ptr >= AUX_HI_BASE) && (ptr <= AUX_HI_END);
		return (AUX_MODE != AUX_NONE) && (lo || (hi && AUX_MODE == AUX_LARGE));
	endfunction

	// memory row for a mapped pointer, low window first
	function automatic logic [6:0] aux_row(input logic [7:0] ptr);
		logic [7:0] row;
		if (ptr <= AUX_LO_END)
			row = ptr - AUX_LO_BASE;
		else
			row = ptr - AUX_HI_BASE + 8'(BVR_AUX_BANK);
		return row[6:0];
	endfunction

	// ----------------------------------------------------------------------
	// state
	// ----------------------------------------------------------------------
	logic [7:0]  gp      [BVR_GP_COUNT];
	logic [7:0]  next_gp [BVR_GP_COUNT];
	logic [7:0]  port_out;
	logic [7:0]  dir;
	logic [7:0]  ir_byte;
	logic [7:0]  aux_ptr;
	logic [7:0]  in_sample;
	logic [7:0]  in_view;
	logic [7:0]  aux_q;
	logic [31:0] rd_mux;
	bvr_phase_t  phase;
	logic        req;
	logic        wr_fire;
	logic        lane0;
	logic        lane1;
	logic        hit_gp;
	logic        hit_word;
	logic        hit_flag;
	logic [3:0]  idx;
	logic [3:0]  alu_dst;
	logic [7:0]  alu_opnd;
	logic        aux_wr;

	// ----------------------------------------------------------------------
	// bus handshake
	// ----------------------------------------------------------------------
	// every access waits two cycles so that aux read data are registered
	assign req             = avs_read || avs_write;
	assign avs_waitrequest = req && (phase != PH_ACK);
	assign wr_fire         = avs_write && (phase == PH_ACK);
	assign lane0           = avs_byteenable[0];
	assign lane1           = avs_byteenable[1];

	// phase walk: idle, wait, ack, then back to idle
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			phase <= PH_IDLE;
		else
		begin
			unique case (phase)
				PH_IDLE: phase <= req ? PH_WAIT : PH_IDLE;
				PH_WAIT: phase <= PH_ACK;
				PH_ACK:  phase <= PH_IDLE;
				default: phase <= PH_IDLE;
			endcase
		end
	end

	// address decode shared by read and write paths
	assign hit_gp   = in_table(avs_address, OFS_GP_BASE, BVR_GP_COUNT);
	assign hit_word = in_table(avs_address, OFS_WORD_BASE, BVR_WORD_COUNT);
	assign hit_flag = in_table(avs_address, OFS_FLAG_BASE, BVR_FLAG_COUNT);
	assign idx      = hit_gp   ? tab_idx(avs_address, OFS_GP_BASE)   :
	                  hit_word ? tab_idx(avs_address, OFS_WORD_BASE) :
	                             tab_idx(avs_address, OFS_FLAG_BASE);
	assign alu_dst  = avs_writedata[ALU_DST_LSB +: 4];
	assign alu_opnd = avs_writedata[ALU_OPND_LSB +: 8];

	// ----------------------------------------------------------------------
	// general byte file
	// ----------------------------------------------------------------------
	// all views write the same bytes, so aliasing needs no extra copy
	always_comb
	begin
		for (int i = 0; i < BVR_GP_COUNT; i++)
			next_gp[i] = gp[i];
		if (wr_fire && lane0)
		begin
			if (hit_gp)
				next_gp[idx] = avs_writedata[7:0];
			else if (hit_word)
			begin
				next_gp[{idx[2:0], 1'b0}] = avs_writedata[7:0];
				if (lane1)
					next_gp[{idx[2:0], 1'b1}] = avs_writedata[15:8];
			end
			else if (hit_flag)
				next_gp[{3'b000, idx[3]}][idx[2:0]] = avs_writedata[0];
			else if (avs_address == OFS_ALU && alu_dst <= BVR_GP_LAST_IDX)
			begin
				// carry and borrow drop out of the 8-bit sum, no flag kept
				if (avs_writedata[ALU_SUB_BIT])
					next_gp[alu_dst] = gp[alu_dst] - alu_opnd;
				else
					next_gp[alu_dst] = gp[alu_dst] + alu_opnd;
			end
			else if (avs_address == OFS_IR && PORT_MODE == PORT_BIDIR)
				next_gp[BVR_GP_LAST_IDX] = avs_writedata[7:0];
		end
		// a code from the receiver wins over a bus write in the same cycle
		if (ir_code_valid && PORT_MODE == PORT_BIDIR)
			next_gp[BVR_GP_LAST_IDX] = ir_code;
	end

	// one flop bank per byte, all cleared together
	genvar g;
	generate
		for (g = 0; g < BVR_GP_COUNT; g++)
		begin : gen_gp
			always_ff @(posedge ref_clk)
			begin
				if (rst)
					gp[g] <= GP_RESET;
				else
					gp[g] <= next_gp[g];
			end
		end
	endgenerate

	// ----------------------------------------------------------------------
	// infrared register for the split-port build
	// ----------------------------------------------------------------------
	// receiver wins over a bus write landing on the same edge
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			ir_byte <= IR_RESET;
		else if (PORT_MODE == PORT_SPLIT && ir_code_valid)
			ir_byte <= ir_code;
		else if (PORT_MODE == PORT_SPLIT && wr_fire && lane0 && avs_address == OFS_IR)
			ir_byte <= avs_writedata[7:0];
	end

	// ----------------------------------------------------------------------
	// port pins
	// ----------------------------------------------------------------------
	// pins are taken as synchronous, so one flop is enough
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			in_sample <= 8'h00;
		else
			in_sample <= in_pins;
	end

	// the two-way build only keeps input bits 1 to 4
	assign in_view = (PORT_MODE == PORT_BIDIR) ?
	                 (in_sample & PORT_BIDIR_IN_MASK) : in_sample;

	// output latch: direct write or copy of the inputs
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			port_out <= PORT_OUT_RESET;
		else if (wr_fire && lane0 && avs_address == OFS_PORT)
			port_out <= avs_writedata[7:0];
		else if (wr_fire && avs_address == OFS_PORT_COPY)
			port_out <= in_view;
	end

	// direction bits exist only for two-way pins 1, 2 and 4
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			dir <= DIR_RESET;
		else if (PORT_MODE == PORT_BIDIR && wr_fire && lane0 && avs_address == OFS_DIR)
			dir <= avs_writedata[7:0] & DIR_IMPL_MASK;
	end

	// split build drives every output pin; two-way build obeys dir
	assign out_pins    = port_out;
	assign out_pins_oe = (PORT_MODE == PORT_BIDIR) ? dir : 8'hff;

	// ----------------------------------------------------------------------
	// auxiliary store
	// ----------------------------------------------------------------------
	// pointer register, the only way into the store
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			aux_ptr <= AUX_PTR_RESET;
		else if (wr_fire && lane0 && avs_address == OFS_AUX_PTR)
			aux_ptr <= avs_writedata[7:0];
	end

	// unmapped pointers drop writes; the arithmetic path never sees the store
	assign aux_wr = wr_fire && lane0 && avs_address == OFS_AUX_DATA &&
	                aux_mapped(aux_ptr);

	bvr_aux_ram u_aux
	(
		.ref_clk (ref_clk),
		.wr_en   (aux_wr),
		.wr_idx  (aux_row(aux_ptr)),
		.wr_data (avs_writedata[7:0]),
		.rd_idx  (aux_row(aux_ptr)),
		.rd_data (aux_q)
	);

	// ----------------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------------
	// unmapped offsets read as zero, upper bits always zero
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (hit_gp)
			rd_mux[7:0] = gp[idx];
		else if (hit_word)
			rd_mux[15:0] = {gp[{idx[2:0], 1'b1}], gp[{idx[2:0], 1'b0}]};
		else if (hit_flag)
			rd_mux[0] = gp[{3'b000, idx[3]}][idx[2:0]];
		else
		begin
			unique case (avs_address)
				OFS_PORT:     rd_mux[7:0] = in_view;
				OFS_DIR:      rd_mux[7:0] = dir;
				OFS_IR:       rd_mux[7:0] = (PORT_MODE == PORT_BIDIR) ?
				                            gp[BVR_GP_LAST_IDX] : ir_byte;
				OFS_AUX_PTR:  rd_mux[7:0] = aux_ptr;
				OFS_AUX_DATA: rd_mux[7:0] = aux_mapped(aux_ptr) ? aux_q : 8'h00;
				default:      rd_mux = 32'h0000_0000;
			endcase
		end
	end

	// read data settle in the wait cycle and stand through the ack cycle
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			avs_readdata <= 32'h0000_0000;
		else if (avs_read && phase == PH_WAIT)
			avs_readdata <= rd_mux;
	end
endmodule
`default_nettype wire

// >>> test/bvr_chk.sv
// assertion checker for the byte variable file ports
`timescale 1ns/1ps
`default_nettype none
module bvr_chk
	import bvr_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// bus
	input  wire logic [11:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest,
	// pins
	input  wire logic [7:0]  in_pins,
	input  wire logic [7:0]  out_pins,
	input  wire logic [7:0]  out_pins_oe,
	input  wire logic        ir_code_valid,
	input  wire logic [7:0]  ir_code
);
	// -------------
	// checks
	// -------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// ack cycles; lane0 is needed for a byte write to land, except a port copy write
	wire logic req = avs_read | avs_write;
	wire logic wr_ack = avs_write & ~avs_waitrequest & avs_byteenable[0];
	wire logic rd_ack = avs_read & ~avs_waitrequest;

	AST_TWO_WAITS: assert property (
		$rose(req) |-> avs_waitrequest[*2] ##1 !avs_waitrequest)
		else $error("bus answer not after two wait cycles");
	AST_IDLE_NO_WAIT: assert property (
		!req |-> !avs_waitrequest)
		else $error("waitrequest high with no request");
	AST_RESET_CLEARS: assert property (disable iff (1'b0)
		rst |=> out_pins == PORT_OUT_RESET && avs_readdata == 32'h0)
		else $error("outputs not cleared by reset");
	AST_PORT_DRIVE: assert property (
		wr_ack && avs_address == OFS_PORT
		|=> out_pins == $past(avs_writedata[7:0]))
		else $error("port write not on output pins");
	AST_PORT_READ: assert property (
		rd_ack && avs_address == OFS_PORT
		|-> avs_readdata[7:0] == $past(in_pins, 2))
		else $error("port read not the sampled inputs");
	AST_PORT_COPY: assert property (
		wr_ack && avs_address == OFS_PORT_COPY
		|=> out_pins == $past(in_pins, 2))
		else $error("port copy did not move inputs to outputs");
	AST_SPLIT_OE_FULL: assert property (
		out_pins_oe == 8'hff)
		else $error("split build must drive every pin");
	AST_OUT_CAUSE: assert property (
		!$stable(out_pins) |-> $past(wr_ack))
		else $error("output pins changed without a write");
endmodule
`default_nettype wire

// >>> test/bvr_pins_model.sv
// far-side model: input pins and infrared receiver
`timescale 1ns/1ps
`default_nettype none
module bvr_pins_model
(
	// clock
	input  wire logic       ref_clk,
	// toward the file
	output logic      [7:0] in_pins,
	output logic            ir_code_valid,
	output logic      [7:0] ir_code
);
	// -------------
	// pin drivers
	// -------------
	logic [7:0] ir_val = 8'h00;
	logic [7:0] junk = 8'h5a;
	initial
	begin
		in_pins = 8'h00;
		ir_code_valid = 1'b0;
	end
	// code bus churns outside the pulse so a late capture cannot pass
	always @(posedge ref_clk)
		junk <= junk + 8'h35;
	assign ir_code = ir_code_valid ? ir_val : junk;
	// change pins just after an edge
	task set_pins(input logic [7:0] v);
		@(posedge ref_clk);
		in_pins <= v;
	endtask
	// one-cycle code pulse
	task send_ir(input logic [7:0] c);
		@(posedge ref_clk);
		ir_val <= c;
		ir_code_valid <= 1'b1;
		@(posedge ref_clk);
		ir_code_valid <= 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> test/testbench.sv
// self-checking bench: bus master, pin model, read scoreboard
`timescale 1ns/1ps
`default_nettype none
module testbench
	import bvr_pkg::*;
;
	// -------------
	// signals
	// -------------
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic [11:0] avs_address = 12'h000;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [7:0]  in_pins;
	logic [7:0]  out_pins;
	logic [7:0]  out_pins_oe;
	logic [7:0]  ir_code;
	logic        ir_code_valid;
	int          err_total = 0;
	int          samples_checked = 0;
	logic [31:0] exp_q[$];
	logic [7:0]  gp[14];
	logic [7:0]  v;
	int          i;

	initial
	forever #4 ref_clk = ~ref_clk;

	bvr_var_file u_dut (.ref_clk(ref_clk), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .in_pins(in_pins),
		.out_pins(out_pins), .out_pins_oe(out_pins_oe),
		.ir_code_valid(ir_code_valid), .ir_code(ir_code));
	bvr_pins_model u_pins (.ref_clk(ref_clk), .in_pins(in_pins),
		.ir_code_valid(ir_code_valid), .ir_code(ir_code));

	// -------------
	// tasks
	// -------------
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e)
		begin
			$display("mismatch %s expected %h seen %h", nm, e, s);
			err_total++;
		end
	endtask
	task report_and_stop();
		if (err_total == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// one access, held until waitrequest is seen low at an edge
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] be);
		int n;
		n = 0;
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_read <= !w;
		avs_write <= w;
		// waitrequest is read at the rising edge itself, before it moves
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (avs_waitrequest && n < 20);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 20)
		begin
			err_total++;
			report_and_stop();
		end
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hf);
	endtask
	// the expectation is noted before the request goes out
	task rd(input logic [11:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0, 4'hf);
	endtask
	function automatic logic [11:0] at(input logic [11:0] b, input int k);
		return b + 12'(4 * k);
	endfunction

	// scoreboard: read data stands in the ack cycle
	always @(negedge ref_clk)
		if (avs_read && !avs_waitrequest && exp_q.size() > 0)
			chk("readdata", exp_q.pop_front(), avs_readdata);

	// -------------
	// main sequence
	// -------------
	initial
	begin
		v = 8'($urandom(32'h8a766c9c));
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		for (i = 0; i < 14; i++)
			rd(at(OFS_GP_BASE, i), 32'h0);
		rd(at(OFS_WORD_BASE, 6), 32'h0);
		rd(OFS_IR, 32'h0);
		// random fill, then every view of it
		for (i = 0; i < 14; i++)
		begin
			gp[i] = 8'($urandom);
			wr(at(OFS_GP_BASE, i), {24'h0, gp[i]});
		end
		for (i = 0; i < 14; i++)
			rd(at(OFS_GP_BASE, i), {24'h0, gp[i]});
		for (i = 0; i < 7; i++)
			rd(at(OFS_WORD_BASE, i), {16'h0, gp[2*i+1], gp[2*i]});
		for (i = 0; i < 16; i++)
			rd(at(OFS_FLAG_BASE, i), {31'h0, gp[i/8][i%8]});
		// last word view into its two bytes, next access
		wr(at(OFS_WORD_BASE, 6), 32'h0000a55a);
		rd(at(OFS_GP_BASE, 12), 32'h5a);
		rd(at(OFS_GP_BASE, 13), 32'ha5);
		// end flags of byte one
		wr(at(OFS_FLAG_BASE, 15), 32'h1);
		wr(at(OFS_FLAG_BASE, 8), 32'h0);
		rd(at(OFS_GP_BASE, 1), {24'h0, 1'b1, gp[1][6:1], 1'b0});
		// lane0 off: byte write refused
		bus(1'b1, at(OFS_GP_BASE, 2), 32'hff, 4'he);
		rd(at(OFS_GP_BASE, 2), {24'h0, gp[2]});
		// wrap both ways with no flag
		wr(at(OFS_GP_BASE, 5), 32'hfe);
		wr(OFS_ALU, 32'h0503);
		rd(at(OFS_GP_BASE, 5), 32'h01);
		wr(at(OFS_GP_BASE, 6), 32'h02);
		wr(OFS_ALU, 32'h1603);
		rd(at(OFS_GP_BASE, 6), 32'hff);
		// aux store: low window edges, the address just below it and the high window base
		wr(OFS_AUX_PTR, 32'h50);
		wr(OFS_AUX_DATA, 32'h11);
		wr(OFS_AUX_PTR, 32'h7f);
		wr(OFS_AUX_DATA, 32'h22);
		wr(OFS_AUX_PTR, 32'h4f);
		wr(OFS_AUX_DATA, 32'h33);
		wr(OFS_AUX_PTR, 32'h50);
		rd(OFS_AUX_DATA, 32'h11);
		wr(OFS_AUX_PTR, 32'h7f);
		rd(OFS_AUX_DATA, 32'h22);
		wr(OFS_AUX_PTR, 32'h4f);
		rd(OFS_AUX_DATA, 32'h0);
		wr(OFS_AUX_PTR, 32'hc0);
		rd(OFS_AUX_DATA, 32'h0);
		// port: outputs, inputs and the copy
		v = 8'($urandom);
		wr(OFS_PORT, {24'h0, v});
		@(negedge ref_clk);
		chk("out_pins", {24'h0, v}, {24'h0, out_pins});
		u_pins.set_pins(~v);
		repeat (3) @(posedge ref_clk);
		rd(OFS_PORT, {24'h0, ~v});
		wr(OFS_PORT_COPY, 32'h0);
		@(negedge ref_clk);
		chk("out_pins", {24'h0, ~v}, {24'h0, out_pins});
		// infrared code captured into its own register
		u_pins.send_ir(8'hc3);
		rd(OFS_IR, 32'hc3);
		// unmapped place
		wr(12'hffc, 32'hff);
		rd(12'hffc, 32'h0);
		// reset in mid-run
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		for (i = 0; i < 14; i++)
			rd(at(OFS_GP_BASE, i), 32'h0);
		chk("out_pins", 32'h0, {24'h0, out_pins});
		report_and_stop();
	end
endmodule

bind bvr_var_file bvr_chk u_chk (.ref_clk(ref_clk), .rst(rst),
	.avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .in_pins(in_pins),
	.out_pins(out_pins), .out_pins_oe(out_pins_oe),
	.ir_code_valid(ir_code_valid), .ir_code(ir_code));
`default_nettype wire
